//--- bench/usb_host_model.sv
// usb host and programming host model driving the device pins
`timescale 1ns/1ps
module usb_host_model
(
  input wire logic clk,
  input wire logic in_ready,
  output logic bus_idle,
  output logic sof,
  output logic host_stop,
  output logic in_valid,
  output usb_suspend_pkg::sample_pair_t in_data,
  output logic in_last,
  output logic sample_tick,
  output logic power_select,
  output logic descriptor_source,
  output logic prog_req
);
  import usb_suspend_pkg::*;
  // board-side duties; the device has no pin for any of them
  logic serial_select_line;
  logic vbus_present;
  logic dp_pullup;
  initial
  begin
    {bus_idle, sof, host_stop, in_valid, in_last, sample_tick} = '0;
    {power_select, descriptor_source, prog_req} = '0;
    in_data = 32'h0;
    serial_select_line = 1'b1;
    vbus_present = 1'b0;
    dp_pullup = 1'b0;
  end
  // k: 2 frame start, 1 stop, 0 sample strobe
  task automatic pulse(input int k);
    @(posedge clk);
    {sof, host_stop, sample_tick} <= 3'(1 << k);
    @(posedge clk);
    {sof, host_stop, sample_tick} <= 3'h0;
  endtask
  task automatic push(input sample_pair_t d, input logic last);
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= d;
    in_last <= last;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    // released lines do not keep the last word
    in_data <= ~d;
    in_last <= ~last;
  endtask
  task automatic hold_bus(input logic v, input int n);
    @(posedge clk);
    bus_idle <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // select stays high until the host is ready to send words
  task automatic straps(input logic ps, input logic ds, input logic req);
    @(posedge clk);
    power_select <= ps;
    descriptor_source <= ds;
    prog_req <= req;
    serial_select_line <= !req;
  endtask
  // pull-up only with bus power present and programming finished
  task automatic attach();
    @(posedge clk);
    vbus_present <= 1'b1;
    @(posedge clk);
    dp_pullup <= vbus_present && !prog_req;
  endtask
endmodule // usb_host_model

//--- bench/usb_suspend_playback_control_bench.sv
// self-checking bench for the suspend and playback control block
`timescale 1ns/1ps
`include "usb_suspend_defines.svh"
module usb_suspend_playback_control_bench;
  import usb_suspend_pkg::*;
  localparam int SUSP = 50;
  logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, bus_idle, power_select, sof, host_stop;
  logic descriptor_source, in_valid, in_last, in_ready, sample_tick;
  logic out_active, prog_req, prog_accept, prog_enable, suspend_indicator, irq;
  logic [`AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  axi_resp_t s_axi_bresp, s_axi_rresp;
  sample_pair_t in_data, out_sample;
  sample_pair_t exp_q[$];
  int bad_count, num_checks, seed, i;

  usb_suspend_playback_control #(.SUSP_IDLE_CYCLES(SUSP)) uut (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bus_idle(bus_idle), .power_select(power_select),
    .descriptor_source(descriptor_source), .sof(sof), .host_stop(host_stop),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .in_ready(in_ready), .sample_tick(sample_tick), .out_sample(out_sample),
    .out_active(out_active), .prog_req(prog_req), .prog_accept(prog_accept),
    .prog_enable(prog_enable), .suspend_indicator(suspend_indicator),
    .irq(irq)
  );

  usb_host_model host (
    .clk(clk), .in_ready(in_ready), .bus_idle(bus_idle), .sof(sof),
    .host_stop(host_stop), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .sample_tick(sample_tick),
    .power_select(power_select), .descriptor_source(descriptor_source),
    .prog_req(prog_req)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input axi_resp_t er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) aw_done = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_done = 1'b1;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input axi_resp_t er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
  endtask

  // one strobe, then the popped word or bipolar zero
  task automatic tick(input sample_pair_t e);
    host.pulse(0);
    #1;
    chk("sample", out_sample, e);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial
  begin
    seed = 32'hf84b;
    bad_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("suspend", suspend_indicator, 0);
    chk("sample", out_sample, 0);
    for (i = 0; i < 4; i++)
    begin
      host.straps(i[1], i[0], 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk("prog_enable", prog_enable, i == 3);
      chk("prog_accept", prog_accept, i == 3);
    end
    host.straps(1'b1, 1'b1, 1'b0);
    host.attach();
    rd(`REG_CTRL, 32'h2, `RESP_OKAY);
    rd(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
    rd(8'h10, 32'h0, `RESP_DECERR);
    wr(8'h10, 32'hFFFFFFFF, `RESP_DECERR);
    for (i = 0; i < 8; i++)
    begin
      exp_q.push_back($random(seed));
      host.push(exp_q[i], i == 7);
    end
    tick(32'h0);
    chk("active", out_active, 0);
    host.pulse(2);
    for (i = 0; i < 3; i++) tick(exp_q.pop_front());
    host.pulse(1);
    #1;
    chk("active", out_active, 1);
    chk("in_ready", in_ready, 0);
    while (exp_q.size() > 0) tick(exp_q.pop_front());
    repeat (3) @(posedge clk);
    #1;
    chk("active", out_active, 0);
    chk("sample", out_sample, 0);
    rd(`REG_STATUS, 32'h20, `RESP_OKAY);
    // play enable off refuses audio; software stop drains a primed word
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    chk("in_ready", in_ready, 0);
    rd(`REG_CTRL, 32'h0, `RESP_OKAY);
    wr(`REG_CTRL, 32'h2, `RESP_OKAY);
    exp_q.push_back($random(seed));
    host.push(exp_q[0], 1'b0);
    wr(`REG_CTRL, 32'h3, `RESP_OKAY);
    chk("active", out_active, 1);
    chk("in_ready", in_ready, 0);
    tick(exp_q.pop_front());
    repeat (3) @(posedge clk);
    #1;
    chk("active", out_active, 0);
    chk("sample", out_sample, 0);
    rd(`REG_IRQ_STAT, 32'hC, `RESP_OKAY);
    chk("irq", irq, 0);
    wr(`REG_IRQ_MASK, 32'h4, `RESP_OKAY);
    chk("irq", irq, 1);
    wr(`REG_IRQ_STAT, 32'hF, `RESP_OKAY);
    chk("irq", irq, 0);
    host.hold_bus(1'b1, SUSP - 3);
    host.hold_bus(1'b0, 1);
    host.hold_bus(1'b1, SUSP - 3);
    chk("suspend", suspend_indicator, 0);
    host.hold_bus(1'b1, 8);
    chk("suspend", suspend_indicator, 1);
    rd(`REG_STATUS, 32'h30, `RESP_OKAY);
    host.hold_bus(1'b1, 20);
    chk("suspend", suspend_indicator, 1);
    host.hold_bus(1'b0, 3);
    chk("suspend", suspend_indicator, 0);
    rd(`REG_IRQ_STAT, 32'h3, `RESP_OKAY);
    wr(`REG_IRQ_MASK, 32'h1, `RESP_OKAY);
    chk("irq", irq, 1);
    final_report();
  end
endmodule // usb_suspend_playback_control_bench

//--- hw/sync_2ff.sv
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk)
      begin
        if (!nrst)
        begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end
        else
        begin
          meta_q <= d[i];
          stab_q <= meta_q;
        end
      end
      assign q[i] = stab_q;
    end
  endgenerate
endmodule // sync_2ff

//--- hw/usb_suspend_playback_control.sv
// usb suspend/resume and playback start/stop control with axi4-lite regs
// Functional notes
// RULE_01 - on stop, keep playing until the last buffered sample has gone out
// RULE_02 - enter suspend after about 5 ms of uninterrupted bus idle
// RULE_03 - suspend indicator stays high exactly while suspended
// RULE_04 - any non-idle bus state wakes the device at once
// RULE_05 - descriptor programming accepted only when both straps are high
// RULE_06 - system keeps D+ pull-up off while detached or unpowered
// RULE_07 - programming host holds serial select line high until ready
// RULE_08 - serial programming host keeps pull-up off until programming done
// RULE_09 - system may watch bus supply before enabling the pull-up
// RULE_10 - buffer the first packet, start playback at the next SOF
// RULE_11 - output bipolar zero while idle and waiting for audio
// RULE_12 - every non-idle bus state restarts the idle timer
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "usb_suspend_defines.svh"
module usb_suspend_playback_control #(
  parameter int unsigned SUSP_IDLE_CYCLES = `SUSP_IDLE_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output usb_suspend_pkg::axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output usb_suspend_pkg::axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_idle,
  input wire logic power_select,
  input wire logic descriptor_source,
  input wire logic sof,
  input wire logic host_stop,
  input wire logic in_valid,
  input wire usb_suspend_pkg::sample_pair_t in_data,
  input wire logic in_last,
  output logic in_ready,
  input wire logic sample_tick,
  output usb_suspend_pkg::sample_pair_t out_sample,
  output logic out_active,
  input wire logic prog_req,
  output logic prog_accept,
  output logic prog_enable,
  output logic suspend_indicator,
  output logic irq
);
  import usb_suspend_pkg::*;

  localparam logic [`IDLE_CNT_W-1:0] IDLE_LAST =
    `IDLE_CNT_W'(SUSP_IDLE_CYCLES - 1);

  function automatic logic reg_hit(input logic [`AXI_AW-1:0] a,
                                   input logic [`AXI_AW-1:0] off);
    reg_hit = (a[`AXI_AW-1:2] == off[`AXI_AW-1:2]);
  endfunction

  logic bus_idle_s;
  logic psel_s;
  logic dsrc_s;
  sync_2ff #(.W(3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({bus_idle, power_select, descriptor_source}),
    .q({bus_idle_s, psel_s, dsrc_s})
  );

  // suspend detection
  logic [`IDLE_CNT_W-1:0] idle_cnt_q;
  logic suspend_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      idle_cnt_q <= '0;
    else if (!bus_idle_s)
      idle_cnt_q <= '0; // RULE_12
    else if (idle_cnt_q != IDLE_LAST)
      idle_cnt_q <= idle_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      suspend_q <= 1'b0;
    else if (!bus_idle_s)
      suspend_q <= 1'b0; // RULE_04
    else if (idle_cnt_q == IDLE_LAST)
      suspend_q <= 1'b1; // RULE_02
  end

  assign suspend_indicator = suspend_q; // RULE_03

  // straps are levels, so the gate follows them with sync latency only
  assign prog_enable = psel_s & dsrc_s; // RULE_05
  assign prog_accept = prog_req & prog_enable; // RULE_05

  // register bus
  logic aw_held_q;
  logic w_held_q;
  logic [`AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  axi_resp_t bresp_q;
  logic rvalid_q;
  axi_resp_t rresp_q;
  logic [31:0] rdata_q;
  logic play_en_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic wr_fire;
  logic sw_stop;
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_clr;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      if (reg_hit(awaddr_q, `REG_CTRL) || reg_hit(awaddr_q, `REG_IRQ_STAT) ||
          reg_hit(awaddr_q, `REG_IRQ_MASK) || reg_hit(awaddr_q, `REG_STATUS))
        bresp_q <= `RESP_OKAY;
      else
        bresp_q <= `RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // only byte lane 0 carries writable bits
  logic wr_ctrl;
  logic wr_mask;
  logic wr_stat;
  assign wr_ctrl = wr_fire && wstrb_q[0] && reg_hit(awaddr_q, `REG_CTRL);
  assign wr_mask = wr_fire && wstrb_q[0] && reg_hit(awaddr_q, `REG_IRQ_MASK);
  assign wr_stat = wr_fire && wstrb_q[0] && reg_hit(awaddr_q, `REG_IRQ_STAT);
  assign sw_stop = wr_ctrl && wdata_q[`CTRL_STOP_BIT];
  assign irq_clr = wr_stat ? wdata_q[`IRQ_W-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      play_en_q <= `CTRL_PLAY_EN_RESET;
    else if (wr_ctrl)
      play_en_q <= wdata_q[`CTRL_PLAY_EN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_mask_q <= `IRQ_MASK_RESET;
    else if (wr_mask)
      irq_mask_q <= wdata_q[`IRQ_W-1:0];
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // playback buffer and sequencing
  logic [`SAMPLE_W-1:0] mem_q [`BUF_DEPTH];
  logic [`BUF_AW-1:0] wr_ptr_q;
  logic [`BUF_AW-1:0] rd_ptr_q;
  logic [`BUF_AW:0] count_q;
  play_state_t state_q;
  play_state_t state_d;
  logic push;
  logic pop;
  logic stop_req;
  logic playing;
  sample_pair_t out_q;

  assign stop_req = host_stop || sw_stop;
  assign playing = (state_q == PS_PLAY) || (state_q == PS_DRAIN);
  // no new audio once a stop is pending; only what is held drains out
  assign in_ready = play_en_q && (count_q != `BUF_DEPTH) &&
                    (state_q != PS_DRAIN);
  assign push = in_valid && in_ready;
  assign pop = playing && sample_tick && (count_q != '0);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PS_IDLE:
        if (push)
          state_d = in_last ? PS_WAIT_SOF : PS_PRIME;
      PS_PRIME:
        if (stop_req)
          state_d = PS_DRAIN; // RULE_01
        else if (push && in_last)
          state_d = PS_WAIT_SOF; // RULE_10
      PS_WAIT_SOF:
        if (stop_req)
          state_d = PS_DRAIN; // RULE_01
        else if (sof)
          state_d = PS_PLAY; // RULE_10
      PS_PLAY:
        if (stop_req)
          state_d = PS_DRAIN; // RULE_01
      PS_DRAIN:
        if (count_q == '0)
          state_d = PS_IDLE; // RULE_01
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_q <= PS_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // an underrun plays bipolar zero rather than repeating a stale sample
  always_ff @(posedge clk)
  begin
    if (!nrst)
      out_q <= `BPZ_SAMPLE;
    else if (!playing)
      out_q <= `BPZ_SAMPLE; // RULE_11
    else if (pop)
      out_q <= mem_q[rd_ptr_q]; // RULE_01
    else if (sample_tick)
      out_q <= `BPZ_SAMPLE;
  end

  assign out_sample = out_q;
  assign out_active = playing;

  logic suspend_prev_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      suspend_prev_q <= 1'b0;
    else
      suspend_prev_q <= suspend_q;
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[`IRQ_SUSPEND_BIT] = suspend_q && !suspend_prev_q;
    irq_ev[`IRQ_RESUME_BIT] = !suspend_q && suspend_prev_q;
    irq_ev[`IRQ_STOPPED_BIT] = (state_q == PS_DRAIN) && (state_d == PS_IDLE);
    irq_ev[`IRQ_PLAY_BIT] = (state_q == PS_WAIT_SOF) && (state_d == PS_PLAY);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rvalid_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rvalid_q <= 1'b1;
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
      if (reg_hit(s_axi_araddr, `REG_CTRL))
        rdata_q[`CTRL_PLAY_EN_BIT] <= play_en_q;
      else if (reg_hit(s_axi_araddr, `REG_STATUS))
      begin
        rdata_q[`ST_STATE_LSB +: 3] <= state_q;
        rdata_q[`ST_SUSPEND_BIT] <= suspend_q;
        rdata_q[`ST_PROG_EN_BIT] <= prog_enable;
        rdata_q[`ST_LEVEL_LSB +: `BUF_AW+1] <= count_q;
      end
      else if (reg_hit(s_axi_araddr, `REG_IRQ_STAT))
        rdata_q[`IRQ_W-1:0] <= irq_stat_q;
      else if (reg_hit(s_axi_araddr, `REG_IRQ_MASK))
        rdata_q[`IRQ_W-1:0] <= irq_mask_q;
      else
        rresp_q <= `RESP_DECERR;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_SUSP_ENTER: assert property ( // RULE_02
    bus_idle_s && idle_cnt_q == IDLE_LAST |=> suspend_q)
    else $error("suspend not entered after idle period");
  AST_SUSP_NOT_EARLY: assert property ( // RULE_02
    $rose(suspend_q) |-> $past(idle_cnt_q) == IDLE_LAST)
    else $error("suspend entered before idle period ended");
  AST_SUSP_HOLD: assert property ( // RULE_03
    suspend_q && bus_idle_s |=> suspend_indicator)
    else $error("suspend indicator dropped while bus idle");
  AST_WAKE: assert property ( // RULE_04
    suspend_q && !bus_idle_s |=> !suspend_indicator)
    else $error("no immediate wake on bus activity");
  AST_TIMER_RESTART: assert property ( // RULE_12
    !bus_idle_s |=> idle_cnt_q == '0 && !suspend_q)
    else $error("idle timer not restarted");
  AST_PROG_GATE: assert property ( // RULE_05
    prog_accept |->
      $past(power_select, 2) && $past(descriptor_source, 2) && prog_req)
    else $error("programming accepted with a strap low");
  AST_WAIT_SOF: assert property ( // RULE_10
    state_q == PS_WAIT_SOF && !sof |=> state_q != PS_PLAY)
    else $error("playback started without SOF");
  AST_START_ON_SOF: assert property ( // RULE_10
    state_q == PS_WAIT_SOF && sof && !stop_req |=> state_q == PS_PLAY)
    else $error("playback not started at SOF");
  AST_BPZ_IDLE: assert property ( // RULE_11
    state_q == PS_IDLE ##1 state_q == PS_IDLE |-> out_sample == '0)
    else $error("idle output not bipolar zero");
  AST_DRAIN_FULL: assert property ( // RULE_01
    state_q == PS_DRAIN && count_q != '0 |=> state_q == PS_DRAIN)
    else $error("playback stopped with data left");
  AST_DRAIN_END: assert property ( // RULE_01
    state_q == PS_DRAIN && count_q == '0 |=> state_q == PS_IDLE)
    else $error("drain did not end when empty");

  COV_SUSPEND: cover property ($rose(suspend_q) ##[1:1000] $fell(suspend_q));
  COV_PLAY: cover property (state_q == PS_WAIT_SOF ##1 state_q == PS_PLAY);
  COV_DRAIN: cover property (state_q == PS_DRAIN ##1 state_q == PS_IDLE);
endmodule // usb_suspend_playback_control

//--- pkg/usb_suspend_defines.svh
// offsets, field positions, reset values and timing counts
`ifndef USB_SUSPEND_DEFINES_SVH
`define USB_SUSPEND_DEFINES_SVH

`define CLK_MHZ 125
`define SUSP_IDLE_US 5000

`define AXI_AW 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`define CTRL_STOP_BIT 0
`define CTRL_PLAY_EN_BIT 1
`define CTRL_PLAY_EN_RESET 1'b1

`define IRQ_W 4
`define IRQ_SUSPEND_BIT 0
`define IRQ_RESUME_BIT 1
`define IRQ_STOPPED_BIT 2
`define IRQ_PLAY_BIT 3
`define IRQ_MASK_RESET 4'h0

`define ST_STATE_LSB 0
`define ST_SUSPEND_BIT 4
`define ST_PROG_EN_BIT 5
`define ST_LEVEL_LSB 8

`define BUF_AW 6
`define BUF_DEPTH 64
`define SAMPLE_W 32
`define BPZ_SAMPLE 32'h0000_0000
`define IDLE_CNT_W 20

`endif

//--- pkg/usb_suspend_pkg.sv
// types shared by the suspend and playback control block
package usb_suspend_pkg;
  typedef enum logic [2:0]
  {
    PS_IDLE,
    PS_PRIME,
    PS_WAIT_SOF,
    PS_PLAY,
    PS_DRAIN
  } play_state_t;
  typedef logic [1:0] axi_resp_t;
  typedef logic [31:0] sample_pair_t;
endpackage
